// ### pfpw_consts.vh
// Constants for the parallel flash page-write block
`ifndef PFPW_CONSTS_VH
`define PFPW_CONSTS_VH
`define PFPW_ACT_ADDR     2'h0
`define PFPW_ACT_DATA     2'h1
`define PFPW_ACT_CMD      2'h2
`define PFPW_CMD_NOP      8'h00
`define PFPW_CMD_WRITE    8'h10
`define PFPW_WRITE_TIME_NS 4500000
`define PFPW_CLK_NS       8
`define PFPW_WRITE_CYCLES (`PFPW_WRITE_TIME_NS / `PFPW_CLK_NS)
`define PFPW_ADDR_RST     8'h00
`define PFPW_REG_CTRL     8'h00
`define PFPW_REG_STAT     8'h04
`define PFPW_REG_PAGE     8'h08
`define PFPW_REG_RDADDR   8'h0c
`define PFPW_REG_RDDATA   8'h10
`define PFPW_CTRL_RST     32'h00000000
`endif

// ### pfpw_top.v
// Parallel flash page-write path with AXI4-Lite register access
`timescale 1ns/1ns
`include "pfpw_consts.vh"
// Overview of operation
// [RULE_01] Action select 01 with byte select 0 and a strobe pulse latches the low data byte.
// [RULE_02] Action select 01 with byte select 1 and a strobe pulse latches the high data byte.
// [RULE_03] Action select 00 with byte select 1 and a strobe pulse latches the address high byte.
// [RULE_04] The programmer repeats address, low and high loads until the page is filled.
// [RULE_05] A low pulse on write strobe programs the buffered page while ready/busy is low.
// [RULE_06] The programmer waits for ready/busy high before the next page or command.
// [RULE_07] The programmer repeats loading and page writes until all pages are done.
// [RULE_08] Action select 10 with data zero and a strobe pulse loads the no-operation command.
// [RULE_09] A latched no-operation command clears every internal write-control signal.
// [RULE_10] Low address bits index the word in the page, high bits select the page.
// [RULE_11] With fewer than 256 words per page the top address low bits become page bits.
// [RULE_12] Action select 00 with byte select 0 and a strobe pulse latches the address low byte.
module pfpw_top #(
  parameter PAGE_BITS   = 5,
  parameter FLASH_WORDS = 4096,
  parameter AW          = 12,
  parameter WRITE_CYCLES = `PFPW_WRITE_CYCLES
) (
  input  wire        CLK,
  input  wire        RESETN,
  input  wire        LOAD_STROBE_PIN,
  input  wire        ACTION_SELECT_HI,
  input  wire        ACTION_SELECT_LO,
  input  wire        BYTE_SELECT,
  input  wire        WRITE_STROBE_N,
  input  wire [7:0]  DATA_IN,
  output wire        READY_BUSY_OUT,
  input  wire [7:0]  S_AXI_AWADDR,
  input  wire        S_AXI_AWVALID,
  output wire        S_AXI_AWREADY,
  input  wire [31:0] S_AXI_WDATA,
  input  wire [3:0]  S_AXI_WSTRB,
  input  wire        S_AXI_WVALID,
  output wire        S_AXI_WREADY,
  output wire [1:0]  S_AXI_BRESP,
  output wire        S_AXI_BVALID,
  input  wire        S_AXI_BREADY,
  input  wire [7:0]  S_AXI_ARADDR,
  input  wire        S_AXI_ARVALID,
  output wire        S_AXI_ARREADY,
  output wire [31:0] S_AXI_RDATA,
  output wire [1:0]  S_AXI_RRESP,
  output wire        S_AXI_RVALID,
  input  wire        S_AXI_RREADY
);
  localparam PW = 1 << PAGE_BITS;
  localparam ST_IDLE = 3'b001;
  localparam ST_PROG = 3'b010;
  localparam ST_DONE = 3'b100;

  // Pin synchronisers
  reg  [13:0] s1_r;
  reg  [13:0] s2_r;
  reg         str_d_r;
  reg         wr_d_r;
  wire        strobe_rise;
  wire        wr_fall;
  wire [1:0]  act;
  wire        bsel;
  wire [7:0]  din;

  reg  [7:0]  addr_lo_r;
  reg  [7:0]  addr_hi_r;
  reg  [7:0]  dlo_r;
  reg  [7:0]  cmd_r;
  reg         wr_en_r;
  reg  [2:0]  state_r;
  reg  [31:0] cnt_r;
  reg  [15:0] page_buf [0:PW-1];
  reg  [PW-1:0] pb_valid_r;
  reg  [15:0] flash [0:FLASH_WORDS-1];
  reg  [31:0] pages_r;
  reg  [AW-1:0] prog_page_r;
  reg  [AW-1:0] rd_addr_r;
  reg         sw_busy_ovr_r;
  wire [15:0] full_addr;
  wire [PAGE_BITS-1:0] word_idx;
  wire [AW-1:0] page_base;
  integer     i;

  assign strobe_rise = s2_r[13] & ~str_d_r;
  assign wr_fall     = ~s2_r[12] & wr_d_r;
  assign act         = s2_r[11:10];
  assign bsel        = s2_r[9];
  assign din         = s2_r[7:0];
  // [RULE_10] Word and page split
  assign full_addr   = {addr_hi_r, addr_lo_r};
  assign word_idx    = full_addr[PAGE_BITS-1:0];
  // [RULE_11] Upper low-byte bits as page
  assign page_base   = {full_addr[AW-1:PAGE_BITS], {PAGE_BITS{1'b0}}};
  // [RULE_05] Busy while programming
  assign READY_BUSY_OUT = (state_r == ST_IDLE) & ~sw_busy_ovr_r;

  always @(posedge CLK) begin
    if (!RESETN) begin
      // Write strobe bit resets to its idle high level so no false fall follows reset
      s1_r    <= 14'h1000;
      s2_r    <= 14'h1000;
      str_d_r <= 1'b0;
      wr_d_r  <= 1'b1;
    end else begin
      s1_r    <= {LOAD_STROBE_PIN, WRITE_STROBE_N, ACTION_SELECT_HI, ACTION_SELECT_LO,
                  BYTE_SELECT, 1'b0, DATA_IN};
      s2_r    <= s1_r;
      str_d_r <= s2_r[13];
      wr_d_r  <= s2_r[12];
    end
  end

  always @(posedge CLK) begin
    if (!RESETN) begin
      addr_lo_r  <= `PFPW_ADDR_RST;
      addr_hi_r  <= `PFPW_ADDR_RST;
      dlo_r      <= 8'h00;
      cmd_r      <= `PFPW_CMD_WRITE;
      wr_en_r    <= 1'b0;
      pb_valid_r <= {PW{1'b0}};
      state_r    <= ST_IDLE;
      cnt_r      <= 32'h00000000;
      pages_r    <= 32'h00000000;
      prog_page_r <= {AW{1'b0}};
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (strobe_rise) begin
            case (act)
              `PFPW_ACT_ADDR: begin
                // [RULE_03] Address high latch
                if (bsel)
                  addr_hi_r <= din;
                // [RULE_12] Address low latch
                else
                  addr_lo_r <= din;
              end
              `PFPW_ACT_DATA: begin
                // [RULE_02] High byte completes word
                if (bsel) begin
                  page_buf[word_idx] <= {din, dlo_r};
                  pb_valid_r[word_idx] <= 1'b1;
                  wr_en_r <= 1'b1;
                end
                // [RULE_01] Low byte latch
                else
                  dlo_r <= din;
              end
              `PFPW_ACT_CMD: begin
                cmd_r <= din;
                // [RULE_08] No-operation command
                if (din == `PFPW_CMD_NOP) begin
                  // [RULE_09] Clear write controls
                  wr_en_r    <= 1'b0;
                  pb_valid_r <= {PW{1'b0}};
                end
              end
              default: ;
            endcase
          end else if (wr_fall && cmd_r != `PFPW_CMD_NOP) begin
            // [RULE_05] Start page program
            prog_page_r <= page_base;
            cnt_r       <= 32'h00000000;
            state_r     <= ST_PROG;
          end
        end
        ST_PROG: begin
          if (cnt_r == WRITE_CYCLES - 1)
            state_r <= ST_DONE;
          else
            cnt_r <= cnt_r + 32'h00000001;
        end
        ST_DONE: begin
          for (i = 0; i < PW; i = i + 1)
            if (pb_valid_r[i])
              flash[prog_page_r + i[AW-1:0]] <= page_buf[i];
          pb_valid_r <= {PW{1'b0}};
          pages_r    <= pages_r + 32'h00000001;
          state_r    <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // AXI4-Lite slave
  reg         aw_got_r;
  reg         w_got_r;
  reg  [7:0]  awaddr_r;
  reg  [31:0] wdata_r;
  reg         bvalid_r;
  reg  [1:0]  bresp_r;
  reg         rvalid_r;
  reg  [31:0] rdata_r;
  reg  [1:0]  rresp_r;
  wire        do_wr;

  assign S_AXI_AWREADY = ~aw_got_r & ~bvalid_r;
  assign S_AXI_WREADY  = ~w_got_r & ~bvalid_r;
  assign S_AXI_BVALID  = bvalid_r;
  assign S_AXI_BRESP   = bresp_r;
  assign S_AXI_ARREADY = ~rvalid_r;
  assign S_AXI_RVALID  = rvalid_r;
  assign S_AXI_RDATA   = rdata_r;
  assign S_AXI_RRESP   = rresp_r;
  assign do_wr = aw_got_r & w_got_r & ~bvalid_r;

  always @(posedge CLK) begin
    if (!RESETN) begin
      aw_got_r      <= 1'b0;
      w_got_r       <= 1'b0;
      awaddr_r      <= 8'h00;
      wdata_r       <= 32'h00000000;
      bvalid_r      <= 1'b0;
      bresp_r       <= 2'h0;
      rvalid_r      <= 1'b0;
      rdata_r       <= 32'h00000000;
      rresp_r       <= 2'h0;
      sw_busy_ovr_r <= 1'b0;
      rd_addr_r     <= {AW{1'b0}};
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_got_r <= 1'b1;
        awaddr_r <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_got_r <= 1'b1;
        wdata_r <= S_AXI_WDATA;
      end
      if (do_wr) begin
        aw_got_r <= 1'b0;
        w_got_r  <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r  <= 2'h0;
        case (awaddr_r)
          `PFPW_REG_CTRL:   sw_busy_ovr_r <= wdata_r[0];
          `PFPW_REG_RDADDR: rd_addr_r <= wdata_r[AW-1:0];
          `PFPW_REG_STAT, `PFPW_REG_PAGE, `PFPW_REG_RDDATA: ;
          default: bresp_r <= 2'h2;
        endcase
      end else if (bvalid_r && S_AXI_BREADY)
        bvalid_r <= 1'b0;
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        rvalid_r <= 1'b1;
        rresp_r  <= 2'h0;
        case (S_AXI_ARADDR)
          `PFPW_REG_CTRL:   rdata_r <= {31'h00000000, sw_busy_ovr_r};
          `PFPW_REG_STAT:   rdata_r <= {19'h0, wr_en_r, READY_BUSY_OUT, state_r, cmd_r};
          `PFPW_REG_PAGE:   rdata_r <= pages_r;
          `PFPW_REG_RDADDR: rdata_r <= {{(32-AW){1'b0}}, rd_addr_r};
          `PFPW_REG_RDDATA: rdata_r <= {16'h0000, flash[rd_addr_r]};
          default: begin
            rdata_r <= 32'h00000000;
            rresp_r <= 2'h2;
          end
        endcase
      end else if (rvalid_r && S_AXI_RREADY)
        rvalid_r <= 1'b0;
    end
  end
endmodule // pfpw_top

// ### pfpw_top_properties.sv
// Port assertions for the page-write block
`timescale 1ns/1ns
module pfpw_top_properties #(parameter WRITE_CYCLES = 8) (
  input wire        CLK,
  input wire        RESETN,
  input wire        WRITE_STROBE_N,
  input wire        READY_BUSY_OUT,
  input wire        S_AXI_BVALID,
  input wire        S_AXI_BREADY,
  input wire [1:0]  S_AXI_BRESP,
  input wire        S_AXI_RVALID,
  input wire        S_AXI_RREADY,
  input wire [31:0] S_AXI_RDATA
);
  reg [31:0] bz_r;
  reg [7:0]  wf_r;
  reg        wd_r;
  // Busy length and cycles since the last write strobe fall
  always @(posedge CLK) begin
    wd_r <= WRITE_STROBE_N;
    bz_r <= (!RESETN || READY_BUSY_OUT) ? 32'h0 : bz_r + 32'h1;
    if (!RESETN) wf_r <= 8'hff;
    else if (wd_r && !WRITE_STROBE_N) wf_r <= 8'h00;
    else if (wf_r != 8'hff) wf_r <= wf_r + 8'h01;
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  sequence s_recent_wr; wf_r < 8'h08; endsequence
  sequence s_full_busy; bz_r == WRITE_CYCLES + 1; endsequence
  chk_busy_cause: assert property ($fell(READY_BUSY_OUT) |-> s_recent_wr)
    else $error("busy without strobe");
  chk_busy_len: assert property ($rose(READY_BUSY_OUT) |-> s_full_busy)
    else $error("busy length");
  chk_busy_hold: assert property (
    !READY_BUSY_OUT && bz_r < WRITE_CYCLES |=> !READY_BUSY_OUT) else $error("busy short");
  chk_bresp_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY
    |=> S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("bresp dropped");
  chk_rdata_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY
    |=> S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("rdata dropped");
  chk_bresp_code: assert property (S_AXI_BVALID |-> !S_AXI_BRESP[0])
    else $error("bresp code");
  chk_bvalid_end: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
    else $error("bvalid stuck");
  chk_rvalid_end: assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID)
    else $error("rvalid stuck");
endmodule // pfpw_top_properties
bind pfpw_top pfpw_top_properties #(.WRITE_CYCLES(WRITE_CYCLES)) u_props (.*);

// ### pfpw_prog_model.sv
// Parallel programmer model driving the page-write pins
`timescale 1ns/1ns
module pfpw_prog_model (
  input  wire       clk,
  input  wire       ready_busy_out,
  output reg        load_strobe_pin = 1'b0,
  output reg        action_select_hi = 1'b0,
  output reg        action_select_lo = 1'b0,
  output reg        byte_select = 1'b0,
  output reg        write_strobe_n = 1'b1,
  output reg  [7:0] data_out = 8'h00
);
  task load(input [1:0] act, input bs, input [7:0] d);
    begin
      @(posedge clk);
      {action_select_hi, action_select_lo} <= act;
      byte_select <= bs;
      data_out <= d;
      repeat (4) @(posedge clk);
      load_strobe_pin <= 1'b1;
      repeat (4) @(posedge clk);
      load_strobe_pin <= 1'b0;
      repeat (4) @(posedge clk);
      data_out <= ~d;
    end
  endtask
  // Write pulse, then wait for ready
  task write_page(output reg seen);
    integer k;
    begin
      seen = 1'b0;
      @(posedge clk);
      write_strobe_n <= 1'b0;
      repeat (4) @(posedge clk);
      write_strobe_n <= 1'b1;
      for (k = 0; k < 100 && !(seen && ready_busy_out); k = k + 1) begin
        @(posedge clk);
        if (!ready_busy_out) seen = 1'b1;
      end
    end
  endtask
endmodule // pfpw_prog_model

// ### pfpw_top_tb.sv
// Self-checking bench for the page-write block
`timescale 1ns/1ns
module pfpw_top_tb;
  reg         clk, rstn, awv, wv, bre, arv, rre, seen, pa, pw, pb;
  reg  [7:0]  awa, ara;
  reg  [31:0] wd, v;
  reg  [1:0]  r;
  wire        rdy, awr, wr, bv, arr, rv, lsp, ash, asl, bsl, wsn;
  wire [7:0]  din;
  wire [1:0]  bres, rres;
  wire [31:0] rdat;
  integer     n_fail, num_checks, cyc;
  pfpw_top #(.WRITE_CYCLES(8)) u_pfpw_top (.CLK(clk), .RESETN(rstn), .LOAD_STROBE_PIN(lsp),
    .ACTION_SELECT_HI(ash), .ACTION_SELECT_LO(asl), .BYTE_SELECT(bsl), .WRITE_STROBE_N(wsn),
    .DATA_IN(din), .READY_BUSY_OUT(rdy), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
    .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(wr), .S_AXI_BRESP(bres), .S_AXI_BVALID(bv), .S_AXI_BREADY(bre),
    .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat),
    .S_AXI_RRESP(rres), .S_AXI_RVALID(rv), .S_AXI_RREADY(rre));
  pfpw_prog_model u_prog (.clk(clk), .ready_busy_out(rdy), .load_strobe_pin(lsp),
    .action_select_hi(ash), .action_select_lo(asl), .byte_select(bsl),
    .write_strobe_n(wsn), .data_out(din));
  initial begin clk = 1'b0; forever #4 clk = ~clk; end
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc > 30000) begin n_fail = n_fail + 1; end_of_test; end
  end
  task chk(input [31:0] g, e);
    begin
      num_checks = num_checks + 1;
      if (g !== e) begin
        n_fail = n_fail + 1;
        $display("Error %0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  task end_of_test;
    begin
      if (n_fail == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
    end
  endtask
  task axw(input [7:0] a, input [31:0] d);
    begin
      awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; pa = 1'b1; pw = 1'b1; pb = 1'b1;
      while (pb) begin
        @(posedge clk);
        if (pa && awr) begin awv <= 1'b0; pa = 1'b0; end
        if (pw && wr) begin wv <= 1'b0; pw = 1'b0; end
        if (bv) begin r = bres; pb = 1'b0; end
      end
    end
  endtask
  task axr(input [7:0] a);
    begin
      ara <= a; arv <= 1'b1; pa = 1'b1; pb = 1'b1;
      while (pb) begin
        @(posedge clk);
        if (pa && arr) begin arv <= 1'b0; pa = 1'b0; end
        if (rv) begin v = rdat; r = rres; pb = 1'b0; end
      end
    end
  endtask
  task rdchk(input [7:0] a, input [31:0] e);
    begin axr(a); chk(v, e); end
  endtask
  task ld_word(input [7:0] a, lo, hi);
    begin
      u_prog.load(2'h0, 1'b0, a);
      u_prog.load(2'h1, 1'b0, lo);
      u_prog.load(2'h1, 1'b1, hi);
    end
  endtask
  task sc_page;
    begin
      ld_word(8'h23, 8'h5a, 8'hc3);
      ld_word(8'h3f, 8'h0f, 8'hf0);
      u_prog.load(2'h0, 1'b1, 8'h01);
      u_prog.write_page(seen); chk(seen, 1'b1);
      rdchk(8'h08, 32'h1);
      rdchk(8'h04, 32'h1910);
      axw(8'h0c, 32'h123); rdchk(8'h10, 32'hc35a);
      axw(8'h0c, 32'h13f); rdchk(8'h10, 32'hf00f);
    end
  endtask
  task sc_nop;
    begin
      u_prog.load(2'h2, 1'b0, 8'h00);
      rdchk(8'h04, 32'h0900);
      u_prog.write_page(seen); chk(seen, 1'b0);
      rdchk(8'h08, 32'h1);
      u_prog.load(2'h2, 1'b0, 8'h10);
      ld_word(8'h00, 8'h11, 8'h22);
      u_prog.load(2'h0, 1'b1, 8'h00);
      u_prog.write_page(seen); chk(seen, 1'b1);
      rdchk(8'h08, 32'h2);
      axw(8'h0c, 32'h0); rdchk(8'h10, 32'h2211);
    end
  endtask
  task sc_bus;
    begin
      rdchk(8'h08, 32'h0);
      chk(rdy, 1'b1);
      axw(8'h40, 32'h1); chk(r, 2'h2);
      axr(8'h40); chk(r, 2'h2);
    end
  endtask
  initial begin
    n_fail = 0; num_checks = 0; cyc = 0; rstn = 1'b0;
    {awv, wv, arv} = 3'h0; awa = 8'h00; ara = 8'h00; wd = 32'h0;
    bre = 1'b1;
    rre = 1'b1;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    sc_bus; sc_page; sc_nop;
    end_of_test;
  end
endmodule // pfpw_top_tb
